// file: logic/pop_pin.sv
`timescale 1ns/10ps
module pop_pin import pop_pkg::*; (
  // configuration and display inputs
  input wire pop_cfg_t cfg,
  input wire pop_bar_t bar,
  // condition flags
  input wire logic [7:0] safety_flags,
  input wire logic [7:0] charge_flags,
  // level to drive on the pin
  output logic drive_level
);
  logic [7:0] flags;
  logic and_hit;
  logic or_hit;
  logic cond;
  logic seg;
  logic value;

  // condition and segment evaluation
  always_comb begin
    flags = (cfg.mode == POP_CHARGE) ? charge_flags : safety_flags;
    and_hit = (cfg.and_mask != 8'h00) && ((flags & cfg.and_mask) == cfg.and_mask);
    or_hit = |(flags & cfg.or_mask);
    cond = and_hit | or_hit;
    seg = bar.show && (bar.soc > bar.floor_pct);
    if (bar.is_low && (bar.soc < POP_SOC_FLASH) && !bar.flash_on) begin
      seg = 1'b0;
    end
    value = cfg.mode[1] ? seg : cond;
    drive_level = value ^ cfg.pol;
  end
endmodule

// file: logic/pop_pkg.sv
package pop_pkg;
  // sizes
  localparam int POP_NPIN = 6;
  localparam int POP_DW = 8;
  localparam int POP_AW = 6;
  // register offsets
  localparam logic [5:0] POP_ADDR_MODE_LO = 6'h00;
  localparam logic [5:0] POP_ADDR_MODE_HI = 6'h01;
  localparam logic [5:0] POP_ADDR_POL = 6'h02;
  localparam logic [5:0] POP_ADDR_INIT = 6'h03;
  localparam logic [5:0] POP_ADDR_STEP = 6'h04;
  localparam logic [5:0] POP_ADDR_DUR = 6'h05;
  localparam logic [5:0] POP_ADDR_CUR = 6'h06;
  localparam logic [5:0] POP_ADDR_CTRL = 6'h07;
  localparam logic [5:0] POP_ADDR_STATUS = 6'h08;
  localparam logic [5:0] POP_ADDR_PINS = 6'h09;
  localparam logic [5:0] POP_ADDR_AND_BASE = 6'h10;
  localparam logic [5:0] POP_ADDR_OR_BASE = 6'h20;
  // field positions
  localparam int POP_CTRL_START = 0;
  localparam int POP_CTRL_ACTIVE = 1;
  // reset values
  localparam logic [7:0] POP_STEP_RST = 8'h14;
  localparam logic [7:0] POP_DUR_RST = 8'h05;
  localparam logic [7:0] POP_CFG_RST = 8'h00;
  localparam logic [5:0] POP_OE_RST = 6'h20;
  // display limits
  localparam logic [7:0] POP_SOC_FLASH = 8'h0A;
  // flash half period and derived cycle count
  localparam int POP_HALF_MS = 500;
  localparam int POP_CLK_HZ = 40000000;
  localparam int POP_HALF_CYCLES = POP_CLK_HZ / 1000 * POP_HALF_MS;
  // pin modes
  typedef enum logic [1:0] {
    POP_SAFETY = 2'b00,
    POP_CHARGE = 2'b01,
    POP_BAR_TIMED = 2'b10,
    POP_BAR_CHG = 2'b11
  } pop_mode_t;
  // display-window state
  typedef enum logic [0:0] {
    POP_DISP_IDLE = 1'b0,
    POP_DISP_TIMED = 1'b1
  } pop_disp_t;
  // per-pin configuration
  typedef struct packed {
    pop_mode_t mode;
    logic [7:0] and_mask;
    logic [7:0] or_mask;
    logic pol;
  } pop_cfg_t;
  // per-pin bar-graph inputs
  typedef struct packed {
    logic [7:0] soc;
    logic [7:0] floor_pct;
    logic is_low;
    logic flash_on;
    logic show;
  } pop_bar_t;
endpackage

// file: logic/pop_top.sv
`timescale 1ns/10ps
// Overview of operation
// - each pin has a 2-bit mode from low and high mode bytes
// - pin six is driven low right after reset
// - pins one to five are left undriven by reset
// - on start, pins one to five take their initial values
// - mode 00 evaluates AND and OR masks over the flags
// - safety mode: any pin fires on any AND/OR of safety flags
// - charge mode: any pin fires on any AND/OR of charge flags
// - modes 10 and 11 make the pin a bar-graph segment
// - thresholds go low to high over display pins in ascending order
// - lowest display pin flashes while charge is from 1 to 9 percent
// - polarity bit inverts the drive in every mode
// - bar graph shows while the switch input is low
// - mode 10 keeps the display for the programmed duration
// - mode 11 also shows while charging at or above threshold
module pop_top import pop_pkg::*; #(
  parameter int HALF_CYCLES = POP_HALF_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // internal conditions
  input wire logic [7:0] safety_flags,
  input wire logic [7:0] charge_flags,
  input wire logic [7:0] soc_percent,
  input wire logic charging,
  input wire logic [7:0] charge_current,
  // display switch pin
  input wire logic switch_n,
  // output pins
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe
);
  localparam int CW = $clog2(HALF_CYCLES + 1);

  logic [7:0] mode_lo_reg;
  logic [7:0] mode_hi_reg;
  logic [7:0] pol_reg;
  logic [7:0] init_reg;
  logic [7:0] step_reg;
  logic [7:0] dur_reg;
  logic [7:0] cur_reg;
  logic [7:0] and_mask_reg [POP_NPIN];
  logic [7:0] or_mask_reg [POP_NPIN];
  logic started_reg;
  logic active_reg;
  logic [7:0] rdata_reg;
  logic start_pulse;
  logic sw_meta_reg;
  logic sw_sync_reg;
  logic sw_prev_reg;
  logic sw_fall;
  logic sw_low;
  logic [CW-1:0] half_cnt_reg;
  logic half_tick;
  logic flash_reg;
  logic sec_tick;
  pop_disp_t disp_reg;
  logic [7:0] dsec_reg;
  logic show_timed;
  logic show_chg;
  pop_mode_t mode [POP_NPIN];
  logic [2:0] rank [POP_NPIN];
  logic [POP_NPIN-1:0] pin_show;
  logic [POP_NPIN-1:0] drive;
  logic [5:0] pin_out_reg;
  logic [5:0] pin_oe_reg;
  logic or1_hit;

  // write strobe decode
  assign start_pulse = reg_wr && (reg_addr == POP_ADDR_CTRL) && reg_wdata[POP_CTRL_START];

  // configuration register writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_lo_reg <= POP_CFG_RST;
      mode_hi_reg <= POP_CFG_RST;
      pol_reg <= POP_CFG_RST;
      init_reg <= POP_CFG_RST;
      step_reg <= POP_STEP_RST;
      dur_reg <= POP_DUR_RST;
      cur_reg <= POP_CFG_RST;
      active_reg <= 1'b0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        POP_ADDR_MODE_LO: mode_lo_reg <= reg_wdata;
        POP_ADDR_MODE_HI: mode_hi_reg <= reg_wdata;
        POP_ADDR_POL: pol_reg <= reg_wdata;
        POP_ADDR_INIT: init_reg <= reg_wdata;
        POP_ADDR_STEP: step_reg <= reg_wdata;
        POP_ADDR_DUR: dur_reg <= reg_wdata;
        POP_ADDR_CUR: cur_reg <= reg_wdata;
        POP_ADDR_CTRL: active_reg <= reg_wdata[POP_CTRL_ACTIVE];
        default: ;
      endcase
    end
  end

  // activation mask writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < POP_NPIN; i++) begin
        and_mask_reg[i] <= POP_CFG_RST;
        or_mask_reg[i] <= POP_CFG_RST;
      end
    end else if (reg_wr) begin
      for (int i = 0; i < POP_NPIN; i++) begin
        if (reg_addr == POP_ADDR_AND_BASE + 6'(i)) begin
          and_mask_reg[i] <= reg_wdata;
        end
        if (reg_addr == POP_ADDR_OR_BASE + 6'(i)) begin
          or_mask_reg[i] <= reg_wdata;
        end
      end
    end
  end

  // start latch, cleared only by reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      started_reg <= 1'b0;
    end else if (start_pulse) begin
      started_reg <= 1'b1;
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (!reg_rd) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= 8'h00;
      unique case (reg_addr)
        POP_ADDR_MODE_LO: rdata_reg <= mode_lo_reg;
        POP_ADDR_MODE_HI: rdata_reg <= mode_hi_reg;
        POP_ADDR_POL: rdata_reg <= pol_reg;
        POP_ADDR_INIT: rdata_reg <= init_reg;
        POP_ADDR_STEP: rdata_reg <= step_reg;
        POP_ADDR_DUR: rdata_reg <= dur_reg;
        POP_ADDR_CUR: rdata_reg <= cur_reg;
        POP_ADDR_CTRL: rdata_reg <= {6'h00, active_reg, started_reg};
        POP_ADDR_STATUS: rdata_reg <= {4'h0, show_chg, show_timed, flash_reg, disp_reg};
        POP_ADDR_PINS: rdata_reg <= {2'b00, pin_out_reg};
        default: begin
          for (int i = 0; i < POP_NPIN; i++) begin
            if (reg_addr == POP_ADDR_AND_BASE + 6'(i)) begin
              rdata_reg <= and_mask_reg[i];
            end
            if (reg_addr == POP_ADDR_OR_BASE + 6'(i)) begin
              rdata_reg <= or_mask_reg[i];
            end
          end
        end
      endcase
    end
  end

  assign reg_rdata = rdata_reg;

  // switch pin synchroniser and edge detect
  always_ff @(posedge mclk) begin
    if (rst) begin
      sw_meta_reg <= 1'b1;
      sw_sync_reg <= 1'b1;
      sw_prev_reg <= 1'b1;
    end else begin
      sw_meta_reg <= switch_n;
      sw_sync_reg <= sw_meta_reg;
      sw_prev_reg <= sw_sync_reg;
    end
  end

  assign sw_fall = sw_prev_reg && !sw_sync_reg;
  assign sw_low = !sw_sync_reg;

  // half-second timebase
  always_ff @(posedge mclk) begin
    if (rst) begin
      half_cnt_reg <= '0;
    end else if (half_tick) begin
      half_cnt_reg <= '0;
    end else begin
      half_cnt_reg <= half_cnt_reg + 1'b1;
    end
  end

  assign half_tick = (half_cnt_reg == CW'(HALF_CYCLES - 1));

  // flash phase, one full cycle per second
  always_ff @(posedge mclk) begin
    if (rst) begin
      flash_reg <= 1'b0;
    end else if (half_tick) begin
      flash_reg <= !flash_reg;
    end
  end

  assign sec_tick = half_tick && flash_reg;

  // timed display window
  always_ff @(posedge mclk) begin
    if (rst) begin
      disp_reg <= POP_DISP_IDLE;
      dsec_reg <= 8'h00;
    end else if (sw_fall && (dur_reg != 8'h00)) begin
      disp_reg <= POP_DISP_TIMED;
      dsec_reg <= dur_reg;
    end else begin
      unique case (disp_reg)
        POP_DISP_IDLE: dsec_reg <= 8'h00;
        POP_DISP_TIMED: begin
          if (sec_tick) begin
            if (dsec_reg <= 8'h01) begin
              disp_reg <= POP_DISP_IDLE;
              dsec_reg <= 8'h00;
            end else begin
              dsec_reg <= dsec_reg - 8'h01;
            end
          end
        end
      endcase
    end
  end

  assign show_timed = (disp_reg == POP_DISP_TIMED) || sw_low;
  assign show_chg = charging && (charge_current >= cur_reg);

  // mode decode and segment ranking
  always_comb begin
    logic [2:0] cnt;
    cnt = 3'd0;
    for (int i = 0; i < POP_NPIN; i++) begin
      mode[i] = pop_mode_t'({mode_hi_reg[i], mode_lo_reg[i]});
      rank[i] = cnt;
      if (mode[i][1]) begin
        cnt = cnt + 3'd1;
      end
      pin_show[i] = show_timed || ((mode[i] == POP_BAR_CHG) && show_chg);
    end
  end

  // one evaluator per pin
  for (genvar g = 0; g < POP_NPIN; g++) begin : g_pin
    logic [15:0] prod;
    pop_cfg_t cfg;
    pop_bar_t bar;
    assign prod = 16'(rank[g]) * 16'(step_reg);
    assign cfg.mode = mode[g];
    assign cfg.and_mask = and_mask_reg[g];
    assign cfg.or_mask = or_mask_reg[g];
    assign cfg.pol = pol_reg[g];
    assign bar.soc = soc_percent;
    assign bar.floor_pct = (prod[15:8] != 8'h00) ? 8'hFF : prod[7:0];
    assign bar.is_low = (rank[g] == 3'd0);
    assign bar.flash_on = flash_reg;
    assign bar.show = pin_show[g];
    pop_pin u_pin (
      .cfg(cfg),
      .bar(bar),
      .safety_flags(safety_flags),
      .charge_flags(charge_flags),
      .drive_level(drive[g])
    );
  end

  // pin drive registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_out_reg <= 6'h00;
      pin_oe_reg <= POP_OE_RST;
    end else if (start_pulse) begin
      pin_out_reg <= {pin_out_reg[5], init_reg[4:0]};
      pin_oe_reg <= 6'h3F;
    end else if (started_reg && active_reg) begin
      pin_out_reg <= drive;
    end
  end

  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;

  // helper for the mask check on pin two
  assign or1_hit = |(safety_flags & or_mask_reg[1]);

  // checks
  AST_PIN6_LOW: assert property (@(posedge mclk)
    $fell(rst) |-> pin_oe[5] && !pin_out[5])
    else $error("pin six not driven low after reset");

  AST_PINS_UNDRIVEN: assert property (@(posedge mclk) disable iff (rst)
    !started_reg |-> (pin_oe[4:0] == 5'h00))
    else $error("pins one to five driven before start");

  AST_INIT_VALUES: assert property (@(posedge mclk) disable iff (rst)
    start_pulse |=> (pin_out[4:0] == $past(init_reg[4:0])) && (pin_oe == 6'h3F))
    else $error("initial values not applied on start");

  AST_OR_MASK: assert property (@(posedge mclk) disable iff (rst)
    started_reg && active_reg && !start_pulse && (mode[1] == POP_SAFETY)
    && (and_mask_reg[1] == 8'h00)
    |=> pin_out[1] == ($past(or1_hit) ^ $past(pol_reg[1])))
    else $error("pin two does not follow its or mask");

  AST_POLARITY: assert property (@(posedge mclk) disable iff (rst)
    started_reg && active_reg && !start_pulse && !mode[1][1]
    && (and_mask_reg[1] == 8'h00) && (or_mask_reg[1] == 8'h00)
    |=> pin_out[1] == $past(pol_reg[1]))
    else $error("inactive pin two ignores polarity");

  AST_FLASH: assert property (@(posedge mclk) disable iff (rst)
    started_reg && active_reg && !start_pulse && mode[0][1] && pin_show[0]
    && (soc_percent != 8'h00) && (soc_percent < POP_SOC_FLASH) && !flash_reg
    |=> pin_out[0] == $past(pol_reg[0]))
    else $error("lowest segment lit in dark flash phase");

  AST_FLASH_RATE: assert property (@(posedge mclk) disable iff (rst)
    half_tick |=> (flash_reg != $past(flash_reg)) ##1 $stable(flash_reg))
    else $error("flash phase does not toggle on half tick");

  AST_TIMED_START: assert property (@(posedge mclk) disable iff (rst)
    sw_fall && (dur_reg != 8'h00)
    |=> (disp_reg == POP_DISP_TIMED) && (dsec_reg == $past(dur_reg)))
    else $error("switch press did not start display window");

  AST_TIMED_END: assert property (@(posedge mclk) disable iff (rst)
    (disp_reg == POP_DISP_TIMED) && sec_tick && (dsec_reg == 8'h01) && !sw_fall
    |=> disp_reg == POP_DISP_IDLE)
    else $error("display window did not close");

  AST_CHG_SHOW: assert property (@(posedge mclk) disable iff (rst)
    (mode[2] == POP_BAR_CHG) && charging && (charge_current >= cur_reg)
    |-> pin_show[2])
    else $error("charging display not shown");

  AST_RANK: assert property (@(posedge mclk) disable iff (rst)
    mode[5][1] |-> (32'(rank[5]) == $countones(mode_hi_reg[4:0])))
    else $error("top segment rank wrong");

endmodule

// file: testbench/pop_led_model.sv
`timescale 1ns/10ps
// far side: LEDs and switching circuitry on the six output pins
module pop_led_model import pop_pkg::*; (
  // pins from the device
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  // level seen on each pin
  output logic [5:0] pin_level
);
  // an undriven pin floats: show the inverse of the held level, never a stale value
  always_comb begin
    for (int k = 0; k < POP_NPIN; k++) begin
      pin_level[k] = pin_oe[k] ? pin_out[k] : ~pin_out[k];
    end
  end
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top import pop_pkg::*; ;
  logic mclk, rst, reg_wr, reg_rd, charging, switch_n;
  logic [5:0] reg_addr, pin_out, pin_oe, pin_level;
  logic [7:0] reg_wdata, reg_rdata, safety_flags, charge_flags, soc_percent, charge_current, d;
  int num_errors, tests_run, seen0, seen1;
  localparam logic [7:0] SF [4] = '{8'h03, 8'h04, 8'h01, 8'h00};
  localparam logic [7:0] CF [4] = '{8'h00, 8'h00, 8'h81, 8'h80};
  localparam logic [5:0] EX [4] = '{6'h05, 6'h06, 6'h0C, 6'h04};

  // device and far side
  pop_top #(.HALF_CYCLES(8)) pop_top_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .safety_flags(safety_flags), .charge_flags(charge_flags), .soc_percent(soc_percent),
    .charging(charging), .charge_current(charge_current), .switch_n(switch_n),
    .pin_out(pin_out), .pin_oe(pin_oe));
  pop_led_model pop_led_model_i (.pin_out(pin_out), .pin_oe(pin_oe),
    .pin_level(pin_level));

  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // register write, one strobe cycle
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // register read, data stands in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // let inputs pass the switch sync and the output register
  task automatic chk_pins(input logic [5:0] exp);
    cyc(6);
    chk({2'b00, pin_level}, {2'b00, exp});
    // return on an edge so the next stimulus lands on it
    @(posedge mclk);
  endtask
  task automatic cfg(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] pol);
    wr(POP_ADDR_MODE_LO, lo);
    wr(POP_ADDR_MODE_HI, hi);
    wr(POP_ADDR_POL, pol);
  endtask
  task automatic end_test(input string name);
    $display("test %s done, errors so far %0d", name, num_errors);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    print_verdict();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, charging} = 3'h0;
    switch_n = 1'b1;
    reg_addr = 6'h00;
    {reg_wdata, safety_flags, charge_flags, soc_percent, charge_current} = '0;
    num_errors = 0;
    tests_run = 0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    cyc(1);
    chk({2'b00, pin_oe}, 8'h20);
    chk({7'h00, pin_level[5]}, 8'h00);
    rd(POP_ADDR_STEP, d);
    chk(d, POP_STEP_RST);
    rd(POP_ADDR_DUR, d);
    chk(d, POP_DUR_RST);
    rd(6'h3F, d);
    chk(d, 8'h00);
    end_test("reset");
    // start: pins one to five take their initial values
    wr(POP_ADDR_INIT, 8'h15);
    wr(POP_ADDR_CTRL, 8'h01);
    cyc(2);
    chk({2'b00, pin_level}, 8'h15);
    chk({2'b00, pin_oe}, 8'h3F);
    end_test("start");
    // condition modes: pin4 charge mode, pin3 inverted polarity
    cfg(8'h08, 8'h00, 8'h04);
    rd(POP_ADDR_MODE_LO, d);
    chk(d, 8'h08);
    wr(POP_ADDR_AND_BASE + 6'h00, 8'h03);
    wr(POP_ADDR_OR_BASE + 6'h01, 8'h04);
    wr(POP_ADDR_AND_BASE + 6'h03, 8'h81);
    wr(POP_ADDR_CTRL, 8'h03);
    for (int k = 0; k < 4; k++) begin
      safety_flags <= SF[k];
      charge_flags <= CF[k];
      chk_pins(EX[k]);
    end
    rd(POP_ADDR_PINS, d);
    chk(d, {2'b00, EX[3]});
    wr(POP_ADDR_AND_BASE + 6'h00, 8'h00);
    wr(POP_ADDR_OR_BASE + 6'h01, 8'h00);
    wr(POP_ADDR_AND_BASE + 6'h03, 8'h00);
    end_test("conditions");
    // bar graph on pins one to five, active low, step 20, no timed window
    cfg(8'h00, 8'h1F, 8'h1F);
    wr(POP_ADDR_STEP, 8'h14);
    wr(POP_ADDR_DUR, 8'h00);
    soc_percent <= 8'h32;
    switch_n <= 1'b0;
    chk_pins(6'h18);
    switch_n <= 1'b1;
    chk_pins(6'h1F);
    // pins 1,2,3,5 as segments, step 25, boundary at 75
    cfg(8'h00, 8'h17, 8'h17);
    wr(POP_ADDR_STEP, 8'h19);
    soc_percent <= 8'h4B;
    switch_n <= 1'b0;
    chk_pins(6'h10);
    soc_percent <= 8'h4C;
    chk_pins(6'h00);
    // pins 1,2,4,6 as segments: pin six takes the top step
    cfg(8'h00, 8'h2B, 8'h2B);
    soc_percent <= 8'h33;
    chk_pins(6'h20);
    end_test("bar graph");
    // low charge: lowest segment flashes, others dark
    cfg(8'h00, 8'h1F, 8'h1F);
    wr(POP_ADDR_STEP, 8'h14);
    soc_percent <= 8'h05;
    cyc(6);
    seen0 = 0;
    seen1 = 0;
    for (int k = 0; k < 40; k++) begin
      cyc(1);
      if (pin_level[0] === 1'b0) seen0++;
      if (pin_level[0] === 1'b1) seen1++;
    end
    chk(8'(seen0 > 0 && seen1 > 0), 8'h01);
    chk({3'h0, pin_level[5:1]}, 8'h0F);
    @(posedge mclk);
    switch_n <= 1'b1;
    end_test("flash");
    // timed display: three one-second ticks after a short press
    soc_percent <= 8'h64;
    wr(POP_ADDR_DUR, 8'h03);
    repeat (4) @(posedge mclk);
    switch_n <= 1'b0;
    repeat (6) @(posedge mclk);
    switch_n <= 1'b1;
    cyc(18);
    chk({2'b00, pin_level}, 8'h00);
    cyc(36);
    chk({2'b00, pin_level}, 8'h1F);
    end_test("timed");
    // display while charging at or above the threshold
    cfg(8'h1F, 8'h1F, 8'h1F);
    wr(POP_ADDR_DUR, 8'h00);
    wr(POP_ADDR_CUR, 8'h40);
    charging <= 1'b1;
    charge_current <= 8'h40;
    chk_pins(6'h00);
    charge_current <= 8'h3F;
    chk_pins(6'h1F);
    charge_current <= 8'h40;
    charging <= 1'b0;
    chk_pins(6'h1F);
    end_test("charging");
    print_verdict();
  end
endmodule
